// ### stci_pkg.sv
// package: register map, reset values, command codes and timing for the threshold command issuer
package stci_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_A_ADDR = 4'h1;
  localparam logic [3:0] IDX_A_CMD = 4'h2;
  localparam logic [3:0] IDX_B_ADDR = 4'h3;
  localparam logic [3:0] IDX_B_CMD = 4'h4;
  localparam logic [3:0] IDX_RISE_THR = 4'h5;
  localparam logic [3:0] IDX_FALL_THR = 4'h6;
  localparam logic [3:0] IDX_RISE_DLY = 4'h7;
  localparam logic [3:0] IDX_FALL_DLY = 4'h8;
  localparam logic [3:0] IDX_REPEAT = 4'h9;
  localparam logic [3:0] IDX_GAIN = 4'ha;
  localparam logic [3:0] IDX_ILK = 4'hb;
  localparam logic [3:0] IDX_SEQ_SEL = 4'hc;
  localparam logic [3:0] IDX_LOW_LEVEL = 4'hd;
  localparam logic [3:0] IDX_STATUS = 4'he;
  localparam int unsigned NUM_CFG = 14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_TWO_BYTE = 0;
  localparam int unsigned CTRL_MSG = 1;
  localparam int unsigned CTRL_CUSTOM = 2;
  localparam int unsigned CTRL_RELATIVE = 3;
  localparam logic [7:0] CTRL_MASK = 8'h0f;
  localparam int unsigned SEQ_BINARY = 0;
  localparam int unsigned SEQ_LAST_LEVEL = 1;
  localparam int unsigned SEQ_LOW_LEVEL = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h01;
  localparam logic [7:0] RST_A_ADDR = 8'hff;
  localparam logic [7:0] RST_A_CMD = 8'h05;
  localparam logic [7:0] RST_B_ADDR = 8'hff;
  localparam logic [7:0] RST_B_CMD = 8'h00;
  localparam logic [7:0] RST_THR = 8'h01;
  localparam logic [7:0] RST_RISE_DLY = 8'h00;
  localparam logic [7:0] RST_FALL_DLY = 8'h14;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ILK = 8'hff;
  localparam logic [7:0] RST_LOW_LEVEL = 8'h01;

  // ----------------------------------------------------------------
  // addresses, commands, message codes
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  localparam logic [7:0] ADDR_BCAST_ARC = 8'hfe;
  localparam logic [7:0] ILK_NONE = 8'hff;
  localparam logic [7:0] CMD_GOTO_SCENE15 = 8'h1f;
  localparam logic [7:0] CMD_STORE_DTR = 8'h21;
  localparam logic [7:0] CMD_STORE_SCENE15 = 8'h4f;
  localparam logic [7:0] MSG_ACTIVE = 8'h01;
  localparam logic [7:0] MSG_PASSIVE = 8'h00;

  // ----------------------------------------------------------------
  // timing: 15 s tick, four ticks to the minute
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned TICK_S = 15;
  localparam int unsigned TICK_CYC = 32'(CLK_HZ * TICK_S);
  localparam logic [1:0] TICKS_PER_MIN_LOG2 = 2'h2;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } stci_state_t;

  function automatic logic [7:0] reset_value(input logic [3:0] idx);
    case (idx)
      IDX_CTRL: reset_value = RST_CTRL;
      IDX_A_ADDR: reset_value = RST_A_ADDR;
      IDX_A_CMD: reset_value = RST_A_CMD;
      IDX_B_ADDR: reset_value = RST_B_ADDR;
      IDX_B_CMD: reset_value = RST_B_CMD;
      IDX_RISE_THR: reset_value = RST_THR;
      IDX_FALL_THR: reset_value = RST_THR;
      IDX_RISE_DLY: reset_value = RST_RISE_DLY;
      IDX_FALL_DLY: reset_value = RST_FALL_DLY;
      IDX_ILK: reset_value = RST_ILK;
      IDX_LOW_LEVEL: reset_value = RST_LOW_LEVEL;
      default: reset_value = RST_ZERO;
    endcase
  endfunction : reset_value

endpackage : stci_pkg

// ### stci_issuer.sv
// module: sensor threshold command issuer with apb register slave
`timescale 1ns/1ps
`default_nettype none

module stci_issuer #(
  parameter int unsigned TICK_CYCLES = stci_pkg::TICK_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_sensor_stb,
  input wire logic [7:0] i_sensor,
  input wire logic i_ilk_stb,
  input wire logic [7:0] i_ilk_addr,
  output logic o_fwd_req,
  output logic [7:0] o_fwd_addr,
  output logic [7:0] o_fwd_cmd,
  input wire logic i_fwd_done,
  output logic o_msg_req,
  output logic [7:0] o_msg_b0,
  output logic [7:0] o_msg_b1,
  output logic [7:0] o_msg_b2,
  input wire logic i_msg_done,
  output logic [7:0] o_sensor_gain,
  output logic o_gain_auto,
  output logic o_occupied
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [7:0] regs_q [0:13];
  logic [7:0] status;
  logic [3:0] idx;
  logic addr_err;
  logic apb_wr;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign idx = i_paddr[5:2];
  assign addr_err = (i_paddr[1:0] != 2'h0) || (i_paddr[7:6] != 2'h0) ||
                    (idx > stci_pkg::IDX_STATUS);
  assign apb_wr = i_psel && i_penable && pready_q && i_pwrite && !addr_err;

  // zero wait states: pready rises in the cycle after setup
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (i_ce) begin
      pready_q <= i_psel && !i_penable;
      pslverr_q <= i_psel && !i_penable && addr_err;
      if (i_psel && !i_penable && !i_pwrite) begin
        if (addr_err) begin
          prdata_q <= 32'h0;
        end else if (idx == stci_pkg::IDX_STATUS) begin
          prdata_q <= {24'h0, status};
        end else begin
          prdata_q <= {24'h0, regs_q[idx]};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < stci_pkg::NUM_CFG; i++) begin
        regs_q[i] <= stci_pkg::reset_value(4'(i));
      end
    end else if (i_ce && apb_wr && idx != stci_pkg::IDX_STATUS) begin
      if (idx == stci_pkg::IDX_CTRL) begin
        regs_q[idx] <= i_pwdata[7:0] & stci_pkg::CTRL_MASK;
      end else begin
        regs_q[idx] <= i_pwdata[7:0];
      end
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;

  logic [7:0] ctrl;
  logic [7:0] seq_sel;
  logic [7:0] thr_a;
  logic [7:0] thr_b;
  logic [7:0] dly_a;
  logic [7:0] dly_b;
  logic [7:0] rpt;
  logic [7:0] ilk;
  assign ctrl = regs_q[stci_pkg::IDX_CTRL];
  assign seq_sel = regs_q[stci_pkg::IDX_SEQ_SEL];
  assign thr_a = regs_q[stci_pkg::IDX_RISE_THR];
  assign thr_b = regs_q[stci_pkg::IDX_FALL_THR];
  assign dly_a = regs_q[stci_pkg::IDX_RISE_DLY];
  assign dly_b = regs_q[stci_pkg::IDX_FALL_DLY];
  assign rpt = regs_q[stci_pkg::IDX_REPEAT];
  assign ilk = regs_q[stci_pkg::IDX_ILK];
  assign o_sensor_gain = regs_q[stci_pkg::IDX_GAIN];

  // ----------------------------------------------------------------
  // sensor sampling and threshold detection
  // ----------------------------------------------------------------
  logic [7:0] sensor_q;
  logic [7:0] ref_q;
  logic evt_rise;
  logic evt_fall;
  logic ilk_hit;
  logic [8:0] ref_up;
  logic [8:0] cur_down;

  assign ref_up = {1'b0, ref_q} + {1'b0, thr_a};
  assign cur_down = {1'b0, i_sensor} + {1'b0, thr_b};

  always_comb begin
    evt_rise = 1'b0;
    evt_fall = 1'b0;
    if (i_sensor_stb) begin
      if (seq_sel[stci_pkg::SEQ_BINARY]) begin
        evt_rise = (thr_a != 8'h0) && !sensor_q[0] && i_sensor[0];
        evt_fall = (thr_b != 8'h0) && sensor_q[0] && !i_sensor[0];
      end else if (ctrl[stci_pkg::CTRL_RELATIVE]) begin
        evt_rise = (thr_a != 8'h0) && ({1'b0, i_sensor} >= ref_up);
        evt_fall = (thr_b != 8'h0) && (cur_down <= {1'b0, ref_q});
      end else begin
        evt_rise = (sensor_q < thr_a) && (i_sensor >= thr_a);
        evt_fall = (sensor_q > thr_b) && (i_sensor <= thr_b);
      end
    end
  end

  // only a message from the assigned controller counts; 255 disables it
  assign ilk_hit = i_ilk_stb && (ilk != stci_pkg::ILK_NONE) && (i_ilk_addr == ilk);

  // the relative reference moves only when a step fires, so slow drift accumulates
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sensor_q <= 8'h0;
      ref_q <= 8'h0;
    end else if (i_ce && i_sensor_stb) begin
      sensor_q <= i_sensor;
      if (evt_rise || evt_fall || !ctrl[stci_pkg::CTRL_RELATIVE]) begin
        ref_q <= i_sensor;
      end
    end
  end

  // ----------------------------------------------------------------
  // 15 s timebase
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (i_ce) begin
      tick_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
      if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= 32'h0;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // trigger delays
  // ----------------------------------------------------------------
  logic pend_a_q;
  logic pend_b_q;
  logic [7:0] cnt_a_q;
  logic [9:0] cnt_b_q;
  logic fire_a;
  logic fire_b;
  logic occ_q;

  assign fire_a = (evt_rise && dly_a == 8'h0) ||
                  (pend_a_q && tick_q && cnt_a_q == 8'h1 && !evt_fall);
  assign fire_b = (evt_fall && !evt_rise && dly_b == 8'h0) ||
                  (pend_b_q && tick_q && cnt_b_q == 10'h1 && !evt_rise && !ilk_hit);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_a_q <= 1'b0;
      cnt_a_q <= 8'h0;
    end else if (i_ce) begin
      if (evt_rise) begin
        pend_a_q <= (dly_a != 8'h0);
        cnt_a_q <= dly_a;
      end else if (evt_fall) begin
        pend_a_q <= 1'b0;
      end else if (pend_a_q && tick_q) begin
        cnt_a_q <= cnt_a_q - 8'h1;
        pend_a_q <= (cnt_a_q != 8'h1);
      end
    end
  end

  // renewed occupancy cancels the vacancy wait; an interlock message restarts it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_b_q <= 1'b0;
      cnt_b_q <= 10'h0;
    end else if (i_ce) begin
      if (evt_rise) begin
        pend_b_q <= 1'b0;
      end else if (evt_fall) begin
        pend_b_q <= (dly_b != 8'h0);
        cnt_b_q <= {dly_b, stci_pkg::TICKS_PER_MIN_LOG2 & 2'h0};
      end else if (ilk_hit && pend_b_q) begin
        cnt_b_q <= {dly_b, 2'h0};
      end else if (pend_b_q && tick_q) begin
        cnt_b_q <= cnt_b_q - 10'h1;
        pend_b_q <= (cnt_b_q != 10'h1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      occ_q <= 1'b0;
    end else if (i_ce) begin
      if (evt_rise) begin
        occ_q <= 1'b1;
      end else if (fire_b) begin
        occ_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // forward frame sequencer
  // ----------------------------------------------------------------
  stci_pkg::stci_state_t st_q;
  logic kind_q;
  logic [1:0] step_q;
  logic req_a_q;
  logic req_b_q;
  logic fwd_req_q;
  logic [7:0] fwd_addr_q;
  logic [7:0] fwd_cmd_q;
  logic two_en;
  logic last_lvl;
  logic low_lvl;
  logic take;
  logic sel_kind;
  logic [1:0] sel_step;
  logic [1:0] last_step;
  logic [15:0] frame;

  // a broadcast-arc pattern carries the measured level in absolute mode
  function automatic logic [15:0] pattern(input logic [7:0] a, input logic [7:0] c,
                                          input logic rel, input logic [7:0] lvl);
    if (a == stci_pkg::ADDR_BCAST_ARC && !rel) begin
      pattern = {a, lvl};
    end else begin
      pattern = {a, c};
    end
  endfunction : pattern

  assign two_en = ctrl[stci_pkg::CTRL_TWO_BYTE];
  assign last_lvl = ctrl[stci_pkg::CTRL_CUSTOM] && seq_sel[stci_pkg::SEQ_LAST_LEVEL];
  assign low_lvl = ctrl[stci_pkg::CTRL_CUSTOM] && seq_sel[stci_pkg::SEQ_LOW_LEVEL] &&
                   !seq_sel[stci_pkg::SEQ_LAST_LEVEL];
  assign take = (st_q == stci_pkg::ST_IDLE) && (req_a_q || req_b_q) && two_en;

  always_comb begin
    sel_kind = (st_q == stci_pkg::ST_IDLE) ? !req_a_q : kind_q;
    sel_step = (st_q == stci_pkg::ST_IDLE) ? 2'h0 : step_q + 2'h1;
    if (kind_q) begin
      last_step = last_lvl ? 2'h3 : (low_lvl ? 2'h1 : 2'h0);
    end else begin
      last_step = last_lvl ? 2'h1 : 2'h0;
    end
    frame = pattern(regs_q[stci_pkg::IDX_A_ADDR], regs_q[stci_pkg::IDX_A_CMD],
                    ctrl[stci_pkg::CTRL_RELATIVE], sensor_q);
    if (!sel_kind) begin
      if (last_lvl && sel_step == 2'h1) begin
        frame = {stci_pkg::ADDR_BCAST, stci_pkg::CMD_GOTO_SCENE15};
      end
    end else if (last_lvl) begin
      unique case (sel_step)
        2'h0: frame = {stci_pkg::ADDR_BCAST, stci_pkg::CMD_STORE_DTR};
        2'h1: frame = {stci_pkg::ADDR_BCAST, stci_pkg::CMD_STORE_SCENE15};
        2'h2: frame = {stci_pkg::ADDR_BCAST, stci_pkg::CMD_STORE_SCENE15};
        2'h3: frame = pattern(regs_q[stci_pkg::IDX_B_ADDR], regs_q[stci_pkg::IDX_B_CMD],
                              ctrl[stci_pkg::CTRL_RELATIVE], sensor_q);
      endcase
    end else if (low_lvl && sel_step == 2'h0) begin
      frame = {stci_pkg::ADDR_BCAST_ARC, regs_q[stci_pkg::IDX_LOW_LEVEL]};
    end else begin
      frame = pattern(regs_q[stci_pkg::IDX_B_ADDR], regs_q[stci_pkg::IDX_B_CMD],
                      ctrl[stci_pkg::CTRL_RELATIVE], sensor_q);
    end
  end

  // a request raised in the take cycle survives: set wins over clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_a_q <= 1'b0;
      req_b_q <= 1'b0;
    end else if (i_ce) begin
      req_a_q <= fire_a || (req_a_q && two_en && !(take && !sel_kind));
      req_b_q <= fire_b || (req_b_q && two_en && !(take && sel_kind));
    end
  end

  // the next frame is loaded only after the current one is reported done
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= stci_pkg::ST_IDLE;
      kind_q <= 1'b0;
      step_q <= 2'h0;
      fwd_req_q <= 1'b0;
      fwd_addr_q <= 8'h0;
      fwd_cmd_q <= 8'h0;
    end else if (i_ce) begin
      unique case (st_q)
        stci_pkg::ST_IDLE: begin
          if (take) begin
            st_q <= stci_pkg::ST_SEND;
            kind_q <= sel_kind;
            step_q <= 2'h0;
            fwd_req_q <= 1'b1;
            {fwd_addr_q, fwd_cmd_q} <= frame;
          end
        end
        stci_pkg::ST_SEND: begin
          if (i_fwd_done) begin
            if (step_q == last_step) begin
              st_q <= stci_pkg::ST_IDLE;
              fwd_req_q <= 1'b0;
            end else begin
              step_q <= sel_step;
              {fwd_addr_q, fwd_cmd_q} <= frame;
            end
          end
        end
      endcase
    end
  end

  assign o_fwd_req = fwd_req_q;
  assign o_fwd_addr = fwd_addr_q;
  assign o_fwd_cmd = fwd_cmd_q;
  assign o_occupied = occ_q;

  // ----------------------------------------------------------------
  // three-byte messages to other controllers
  // ----------------------------------------------------------------
  logic msg_req_q;
  logic msg_pend_q;
  logic [7:0] last_evt_q;
  logic [7:0] evt_code;
  logic [9:0] rep_cnt_q;
  logic rep_fire;
  logic msg_new;
  logic gain_auto_q;

  assign evt_code = fire_a ? stci_pkg::MSG_ACTIVE : (fire_b ? stci_pkg::MSG_PASSIVE : last_evt_q);
  assign rep_fire = tick_q && (rpt != 8'h0) && (rep_cnt_q <= 10'h1);
  assign msg_new = ctrl[stci_pkg::CTRL_MSG] && (fire_a || fire_b || rep_fire || msg_pend_q);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rep_cnt_q <= 10'h0;
      last_evt_q <= stci_pkg::MSG_PASSIVE;
    end else if (i_ce) begin
      last_evt_q <= evt_code;
      if (fire_a || fire_b || rep_fire) begin
        rep_cnt_q <= {rpt, 2'h0};
      end else if (tick_q && rep_cnt_q != 10'h0) begin
        rep_cnt_q <= rep_cnt_q - 10'h1;
      end
    end
  end

  // the bytes stand until the transmitter takes them; a newer event waits
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      msg_req_q <= 1'b0;
      msg_pend_q <= 1'b0;
      o_msg_b0 <= 8'h0;
      o_msg_b1 <= 8'h0;
      o_msg_b2 <= 8'h0;
    end else if (i_ce) begin
      if (msg_new && (!msg_req_q || i_msg_done)) begin
        msg_req_q <= 1'b1;
        msg_pend_q <= 1'b0;
        o_msg_b0 <= ilk;
        o_msg_b1 <= evt_code;
        // report the sample that fired, not the one before it
        o_msg_b2 <= i_sensor_stb ? i_sensor : sensor_q;
      end else begin
        if (i_msg_done) begin
          msg_req_q <= 1'b0;
        end
        msg_pend_q <= msg_new && ctrl[stci_pkg::CTRL_MSG];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gain_auto_q <= 1'b1;
    end else if (i_ce) begin
      gain_auto_q <= (regs_q[stci_pkg::IDX_GAIN] == 8'h0);
    end
  end

  assign o_msg_req = msg_req_q;
  assign o_gain_auto = gain_auto_q;
  assign status = {2'h0, msg_req_q, req_b_q, req_a_q, pend_b_q, pend_a_q, occ_q};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  frame_hold_a: assert property (i_ce && fwd_req_q && !i_fwd_done |=>
    o_fwd_req && $stable(o_fwd_addr) && $stable(o_fwd_cmd))
    else $error("frame changed before done");
  two_byte_gate_a: assert property (i_ce && st_q == stci_pkg::ST_IDLE && !two_en |=>
    !o_fwd_req) else $error("frame sent while disabled");
  rise_first_a: assert property (i_ce && take && !sel_kind |=>
    o_fwd_req && o_fwd_addr == $past(regs_q[stci_pkg::IDX_A_ADDR]))
    else $error("pattern a address not sent first");
  delay_a_arm_a: assert property (i_ce && evt_rise && dly_a != 8'h0 |=>
    pend_a_q && cnt_a_q == $past(dly_a)) else $error("delay a not armed");
  delay_b_arm_a: assert property (i_ce && evt_fall && !evt_rise && dly_b != 8'h0 |=>
    pend_b_q && cnt_b_q == {$past(dly_b), 2'h0}) else $error("delay b not armed");
  renew_cancel_a: assert property (i_ce && evt_rise |=> !pend_b_q && occ_q)
    else $error("vacancy wait survived occupancy");
  store_twice_a: assert property (i_ce && st_q == stci_pkg::ST_SEND && kind_q && last_lvl &&
    step_q == 2'h1 && i_fwd_done |=> o_fwd_cmd == stci_pkg::CMD_STORE_SCENE15 && o_fwd_req)
    else $error("scene store not repeated");
  msg_gate_a: assert property (!ctrl[stci_pkg::CTRL_MSG] && !msg_req_q |=> !o_msg_req)
    else $error("message sent while disabled");
  ilk_none_a: assert property (ilk == stci_pkg::ILK_NONE |-> !ilk_hit)
    else $error("interlock with no controller assigned");
  arc_level_a: assert property (i_ce && take && !sel_kind && !last_lvl &&
    regs_q[stci_pkg::IDX_A_ADDR] == stci_pkg::ADDR_BCAST_ARC && !ctrl[stci_pkg::CTRL_RELATIVE]
    |=> o_fwd_cmd == $past(sensor_q)) else $error("arc level not from sensor");
  apb_answer_a: assert property (i_ce && i_psel && !i_penable |=> o_pready)
    else $error("apb access not answered");

  occupancy_sent_c: cover property (i_ce && take && !sel_kind ##[1:20] i_fwd_done);
  last_level_done_c: cover property (i_ce && kind_q && last_lvl && step_q == 2'h3 && i_fwd_done);
  message_sent_c: cover property (o_msg_req && i_msg_done);

endmodule : stci_issuer

`default_nettype wire

// ### stci_xmit_model.sv
// transmitter model: acknowledges each held request after a set latency
`timescale 1ns/1ps
`default_nettype none
module stci_xmit_model (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_req,
  input wire logic [3:0] i_lat,
  output logic o_done
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) {cnt_q, o_done} <= 5'h00;
    else begin
      // count restarts after each pulse so a held request is acked again every i_lat+2 cycles
      o_done <= i_req && !o_done && cnt_q == i_lat;
      cnt_q <= (i_req && !o_done && cnt_q != i_lat) ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule : stci_xmit_model
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the threshold command issuer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] RV [0:11] = '{8'h01, 8'hff, 8'h05, 8'hff, 8'h00, 8'h01, 8'h01, 8'h00,
    8'h14, 8'h00, 8'h00, 8'hff};
  logic clk, rst_b, psel, pen, pwr, rdy, serr, sstb, freq, fdone, mreq, mdone, gauto, e;
  logic ce, ilks, occ;
  logic [7:0] paddr, sens, fa, fc, m0, m1, m2, ilka, gain, sh [0:15];
  logic [31:0] pwd, prd, r;
  logic [3:0] lat;
  logic [15:0] fq [$];
  int errors, samples_checked;
  stci_issuer #(.TICK_CYCLES(10)) DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(serr), .i_sensor_stb(sstb), .i_sensor(sens), .i_ilk_stb(ilks),
    .i_ilk_addr(ilka), .o_fwd_req(freq), .o_fwd_addr(fa), .o_fwd_cmd(fc), .i_fwd_done(fdone),
    .o_msg_req(mreq), .o_msg_b0(m0), .o_msg_b1(m1), .o_msg_b2(m2), .i_msg_done(mdone),
    .o_sensor_gain(gain), .o_gain_auto(gauto), .o_occupied(occ));
  stci_xmit_model xf (.i_clk(clk), .i_rst_b(rst_b), .i_req(freq), .i_lat(lat), .o_done(fdone));
  stci_xmit_model xm (.i_clk(clk), .i_rst_b(rst_b), .i_req(mreq), .i_lat(4'h3), .o_done(mdone));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (freq === 1'b1 && fdone === 1'b1) fq.push_back({fa, fc});
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwd} <= {1'b1, w, 2'b00, i, 2'b00, 24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    {e, r} = {serr, prd};
    {psel, pen} <= 2'b00;
    sh[i] = w ? d : r[7:0];
  endtask : apb
  task automatic sense(input logic [7:0] v);
    @(posedge clk);
    {sens, sstb} <= {v, 1'b1};
    @(posedge clk);
    sstb <= 1'b0;
  endtask : sense
  function automatic logic [31:0] pat(input logic b);
    pat = b ? {16'h0, sh[3], sh[4]} : {16'h0, sh[1], sh[2]};
  endfunction : pat
  task automatic take(input logic [31:0] x);
    for (int i = 0; i < 500 && fq.size() == 0; i++) @(posedge clk);
    chk("frame", x, fq.size() > 0 ? {16'h0, fq.pop_front()} : 32'hx);
  endtask : take
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #200us errors++;
    close_out();
  end
  initial begin
    void'($urandom(17));
    {rst_b, psel, pen, pwr, sstb, paddr, sens, pwd, lat, ilks, ilka} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk("gain auto", 1, gauto);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 4'(i), 8'h00);
      chk("reset value", {24'h0, RV[i]}, r);
    end
    apb(1'b0, 4'hf, 8'h00);
    chk("unmapped error", 1, e);
    $display("test reset values done");
    apb(1'b1, 4'ha, 8'h37);
    repeat (2) @(posedge clk);
    chk("gain", 32'h37, gain);
    chk("gain auto", 0, gauto);
    apb(1'b1, 4'h8, 8'h02);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) for (int i = 1; i < 5; i++) apb(1'b1, 4'(i), 8'($urandom) | 8'h01);
      lat <= 4'($urandom_range(6));
      sense(8'h05);
      take(pat(0));
      chk("occupied", 1, occ);
      sense(8'h00);
      // two minutes is eight ticks of ten cycles; nothing may leave before the eighth
      repeat (60) @(posedge clk);
      chk("early frames", 0, fq.size());
      take(pat(1));
      chk("vacant", 0, occ);
      $display("test trigger %0d done", k);
    end
    apb(1'b1, 4'hc, 8'h02);
    apb(1'b1, 4'h0, 8'h05);
    sense(8'h09);
    take(pat(0));
    take(32'h0000ff1f);
    sense(8'h00);
    take(32'h0000ff21);
    take(32'h0000ff4f);
    take(32'h0000ff4f);
    take(pat(1));
    apb(1'b1, 4'h5, 8'h04);
    apb(1'b1, 4'hb, 8'h21);
    apb(1'b1, 4'h0, 8'h0a);
    sense(8'h0f);
    for (int i = 0; i < 30 && mreq !== 1'b1; i++) @(posedge clk);
    chk("message", 32'h0021010f, {8'h00, m0, m1, m2});
    chk("frames off", 0, fq.size());
    $display("test sequences done");
    // rise delay of three ticks, arc level from the sample, cancelled vacancy
    apb(1'b1, 4'h7, 8'h03);
    apb(1'b1, 4'h1, 8'hfe);
    apb(1'b1, 4'h0, 8'h01);
    sense(8'h00);
    sense(8'h09);
    repeat (20) @(posedge clk);
    chk("rise delay", 0, fq.size());
    take(32'h0000fe09);
    // an interlock message five ticks into the eight-tick wait starts it again
    sense(8'h00);
    repeat (50) @(posedge clk);
    {ilks, ilka} <= {1'b1, 8'h21};
    @(posedge clk);
    ilks <= 1'b0;
    repeat (60) @(posedge clk);
    chk("interlock restart", 0, fq.size());
    take(pat(1));
    // a trigger seen while the clock enable is low must leave no trace
    ce <= 1'b0;
    sense(8'h09);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("frozen occupied", 0, occ);
    chk("frozen frames", 0, fq.size());
    $display("test delays done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
